// File: design/supervisor_pkg.sv
`default_nettype none

package supervisor_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam longint unsigned CLK_HZ        = 125_000_000;
   localparam longint unsigned CLK_PERIOD_NS = 8;
   localparam longint unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int              CNT_W         = 31;
   typedef logic [CNT_W-1:0] cnt_t;

   // glitch width and shortest legal kick pulses on the pins, in ns
   localparam longint unsigned MR_GLITCH_NS  = 100;
   localparam longint unsigned KICK1_MIN_NS  = 80;
   localparam longint unsigned KICK2_MIN_NS  = 8000;
   localparam int MR_FILT_CYC    = int'((MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int KICK1_MIN_CYC  = int'(KICK1_MIN_NS / CLK_PERIOD_NS);
   localparam int KICK2_MIN_CYC  = int'(KICK2_MIN_NS / CLK_PERIOD_NS);

   // supervisor periods, in ms (hold, off and timeout values are plain defaults)
   localparam longint unsigned RESET_HOLD_MS   = 200;
   localparam longint unsigned HOLD_FIRST_MS   = 200;
   localparam longint unsigned HOLD_SECOND_MS  = 200;
   localparam longint unsigned POWER_OFF_MS    = 100;
   localparam longint unsigned SEQ_STEP_MS     = 2;
   localparam longint unsigned FLAG_CLEAR_MS   = 10_000;
   localparam longint unsigned WD1_MS_0        = 100;
   localparam longint unsigned WD1_MS_1        = 1600;

   localparam cnt_t HOLD_CYC_DEF   = cnt_t'(RESET_HOLD_MS * CYC_PER_MS);
   localparam cnt_t HOLD1_CYC_DEF  = cnt_t'(HOLD_FIRST_MS * CYC_PER_MS);
   localparam cnt_t HOLD2_CYC_DEF  = cnt_t'(HOLD_SECOND_MS * CYC_PER_MS);
   localparam cnt_t POFF_CYC_DEF   = cnt_t'(POWER_OFF_MS * CYC_PER_MS);
   localparam cnt_t STEP_CYC_DEF   = cnt_t'(SEQ_STEP_MS * CYC_PER_MS);
   localparam cnt_t CLEAR_CYC_DEF  = cnt_t'(FLAG_CLEAR_MS * CYC_PER_MS);
   localparam cnt_t [1:0] WD1_CYC_DEF = {cnt_t'(WD1_MS_1 * CYC_PER_MS), cnt_t'(WD1_MS_0 * CYC_PER_MS)};
   localparam cnt_t [6:0] WD2_CYC_DEF = {
      cnt_t'(16000 * CYC_PER_MS), cnt_t'(12000 * CYC_PER_MS), cnt_t'(8000 * CYC_PER_MS),
      cnt_t'(6000 * CYC_PER_MS),  cnt_t'(4000 * CYC_PER_MS),  cnt_t'(2000 * CYC_PER_MS),
      cnt_t'(1000 * CYC_PER_MS)};

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTRL_ADDR   = 8'h00;
   localparam logic [7:0]  STATUS_ADDR = 8'h04;
   localparam logic [1:0]  RAIL_INPUT  = 2'h3;
   localparam logic [2:0]  WD2_OFF_SEL = 3'h7;
   localparam logic [1:0]  ORDER_SIMUL = 2'h3;

   typedef struct packed {
      logic [2:0] wd2_sel;
      logic       wd1_sel;
      logic [1:0] rail_sel;          // 0 buck, 1 first ldo, 2 second ldo, 3 input supply
      logic [1:0] power_order_sel;
   } ctrl_t;
   localparam ctrl_t CTRL_RST = 8'h01;

   typedef enum logic [5:0] {
      S_RUN      = 6'h01,
      S_HOLD     = 6'h02,
      S_WD2_HOLD = 6'h04,
      S_POFF     = 6'h08,
      S_SEQ      = 6'h10,
      S_HOLD1    = 6'h20
   } sup_state_t;

   typedef struct packed {
      logic       clear_window;
      logic       undervoltage;
      logic       wd1_active;
      logic [2:0] regulator_enable;
      logic       origin_low;
      logic       reset_active;
      sup_state_t state;
   } status_t;

   // pin levels that need no debounce beyond synchronising
   typedef struct packed {
      logic       lock_mode;
      logic       kick1_float;
      logic       undervoltage_lockout;
      logic [3:0] rail_below;
      logic [2:0] enable;
   } pins_t;

   // regulator bits: 0 buck, 1 first ldo, 2 second ldo; [order][step]
   localparam logic [3:0][2:0][2:0] ORDER_TBL = {
      {3'h0, 3'h0, 3'h7},
      {3'h4, 3'h1, 3'h2},
      {3'h4, 3'h2, 3'h1},
      {3'h1, 3'h4, 3'h2}};

endpackage : supervisor_pkg

`default_nettype wire

// File: design/pin_filter.sv
`default_nettype none

module pin_filter #(
   parameter int               WIDTH = 1,
   parameter int               FILT  = 1,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o,
   output logic                  edge_o
);

   logic [WIDTH-1:0] sync1_q;
   logic [WIDTH-1:0] sync2_q;
   logic [WIDTH-1:0] level_q;
   logic [15:0]      cnt_q;
   logic             edge_q;

   wire differs = (sync2_q != level_q);
   // a change is taken only once it has stood FILT cycles
   wire settled = (cnt_q >= 16'(FILT - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= INIT;
         sync2_q <= INIT;
         level_q <= INIT;
         cnt_q   <= 16'h0000;
         edge_q  <= 1'b0;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         edge_q  <= differs & settled;
         if (differs && settled) begin
            level_q <= sync2_q;
            cnt_q   <= 16'h0000;
         end else if (differs) begin
            cnt_q   <= cnt_q + 16'h0001;
         end else begin
            cnt_q   <= 16'h0000;
         end
      end
   end

   assign level_o = level_q;
   assign edge_o  = edge_q;

endmodule : pin_filter

`default_nettype wire

// File: design/supervisor_dual_watchdog.sv
`default_nettype none

module supervisor_dual_watchdog
   import supervisor_pkg::*;
#(
   parameter cnt_t       HOLD_CYC  = supervisor_pkg::HOLD_CYC_DEF,
   parameter cnt_t       HOLD1_CYC = supervisor_pkg::HOLD1_CYC_DEF,
   parameter cnt_t       HOLD2_CYC = supervisor_pkg::HOLD2_CYC_DEF,
   parameter cnt_t       POFF_CYC  = supervisor_pkg::POFF_CYC_DEF,
   parameter cnt_t       STEP_CYC  = supervisor_pkg::STEP_CYC_DEF,
   parameter cnt_t       CLEAR_CYC = supervisor_pkg::CLEAR_CYC_DEF,
   parameter cnt_t [1:0] WD1_CYC   = supervisor_pkg::WD1_CYC_DEF,
   parameter cnt_t [6:0] WD2_CYC   = supervisor_pkg::WD2_CYC_DEF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        manual_reset_n_i,
   input  wire logic        short_wd_kick_i,
   input  wire logic        short_wd_kick_float_i,
   input  wire logic        long_wd_kick_i,
   input  wire logic        short_wd_lock_mode_i,
   input  wire logic [3:0]  rail_below_i,
   input  wire logic        undervoltage_lockout_i,
   input  wire logic [2:0]  regulator_enable_i,
   output logic             reset_out_n_o,
   output logic             reset_out_oe_o,
   output logic             reset_origin_flag_o,
   output logic             reset_origin_flag_oe_o,
   output logic      [2:0]  regulator_enable_o
);

   // ---------------------------------------------------------------
   // pin conditioning
   // ---------------------------------------------------------------
   pins_t pins_lvl;
   logic  mr_lvl;
   logic  kick1_edge;
   logic  kick2_edge;

   pin_filter #(.WIDTH($bits(pins_t)), .FILT(1), .INIT('0)) u_pins (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   ({short_wd_lock_mode_i, short_wd_kick_float_i, undervoltage_lockout_i,
                 rail_below_i, regulator_enable_i}),
      .level_o (pins_lvl),
      .edge_o  ()
   );

   pin_filter #(.WIDTH(1), .FILT(MR_FILT_CYC), .INIT(1'b1)) u_mr (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (manual_reset_n_i),
      .level_o (mr_lvl),
      .edge_o  ()
   );

   // half the shortest legal pulse: noise rejected, real kicks always seen
   pin_filter #(.WIDTH(1), .FILT(KICK1_MIN_CYC / 2), .INIT(1'b0)) u_kick1 (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (short_wd_kick_i),
      .level_o (),
      .edge_o  (kick1_edge)
   );

   pin_filter #(.WIDTH(1), .FILT(KICK2_MIN_CYC / 2), .INIT(1'b0)) u_kick2 (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (long_wd_kick_i),
      .level_o (),
      .edge_o  (kick2_edge)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   ctrl_t      ctrl_q;
   sup_state_t state_q,     state_d;
   cnt_t       phase_cnt_q, phase_cnt_d;
   cnt_t       wd1_cnt_q,   wd1_cnt_d;
   cnt_t       wd2_cnt_q,   wd2_cnt_d;
   cnt_t       clear_cnt_q;
   logic [1:0] step_q,      step_d;
   logic [2:0] mask_q,      mask_d;
   logic       flag_q,      flag_d;
   logic       win_q;
   logic       rst_prev_q;
   logic       oe_q;
   logic [2:0] reg_en_q;
   logic       ack_q;
   logic [31:0] dat_q;

   wire  uv           = pins_lvl.rail_below[ctrl_q.rail_sel]
                      | ((ctrl_q.rail_sel == RAIL_INPUT) & pins_lvl.undervoltage_lockout);
   wire  level_cause  = uv | ~mr_lvl;
   // reset asserted by level causes or any non-run state
   wire  rst_active   = (state_q != S_RUN) | level_cause;
   wire  wd1_active   = pins_lvl.lock_mode | ~pins_lvl.kick1_float;
   wire  cnt_t wd1_lim = WD1_CYC[ctrl_q.wd1_sel];
   wire  wd2_on       = (ctrl_q.wd2_sel != WD2_OFF_SEL);
   wire  cnt_t wd2_lim = wd2_on ? WD2_CYC[ctrl_q.wd2_sel] : cnt_t'(1);
   wire  wd1_exp      = wd1_active & (wd1_cnt_q >= wd1_lim - cnt_t'(1));
   wire  wd2_exp      = wd2_on & (wd2_cnt_q >= wd2_lim - cnt_t'(1));
   wire  trip_long    = (state_q == S_RUN) & wd2_exp;
   wire  trip_other   = (state_q == S_RUN) & ~wd2_exp & (level_cause | wd1_exp);
   wire  rst_rise     = rst_prev_q & ~rst_active;
   wire  clear_done   = win_q & (clear_cnt_q >= CLEAR_CYC - cnt_t'(1));

   cnt_t phase_lim;
   always_comb begin
      case (state_q)
         S_WD2_HOLD: phase_lim = HOLD2_CYC;
         S_POFF:     phase_lim = POFF_CYC;
         S_SEQ:      phase_lim = STEP_CYC;
         S_HOLD1:    phase_lim = HOLD1_CYC;
         default:    phase_lim = HOLD_CYC;
      endcase
   end
   wire phase_done = (phase_cnt_q >= phase_lim - cnt_t'(1));
   wire cnt_t phase_inc = phase_cnt_q + cnt_t'(1);

   // ---------------------------------------------------------------
   // watchdog counters
   // ---------------------------------------------------------------
   always_comb begin
      // first counter cleared by kick, reset or disable
      if (rst_active || !wd1_active || kick1_edge) begin
         wd1_cnt_d = '0;
      end else if (!wd1_exp) begin
         wd1_cnt_d = wd1_cnt_q + cnt_t'(1);
      end else begin
         wd1_cnt_d = wd1_cnt_q;
      end
      if (rst_active || !wd2_on || kick2_edge) begin
         wd2_cnt_d = '0;
      end else if (!wd2_exp) begin
         wd2_cnt_d = wd2_cnt_q + cnt_t'(1);
      end else begin
         wd2_cnt_d = wd2_cnt_q;
      end
   end

   // ---------------------------------------------------------------
   // reset sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_d     = state_q;
      phase_cnt_d = phase_inc;
      step_d      = step_q;
      mask_d      = mask_q;
      case (state_q)
         S_RUN: begin
            phase_cnt_d = '0;
            // long expiry takes priority over other causes
            if (trip_long) begin
               state_d = S_WD2_HOLD;
            end else if (trip_other) begin
               state_d = S_HOLD;
            end
         end
         S_HOLD, S_HOLD1: begin
            // hold restarts while a level cause persists
            if (level_cause) begin
               phase_cnt_d = '0;
            end else if (phase_done) begin
               state_d     = S_RUN;
               phase_cnt_d = '0;
            end
         end
         S_WD2_HOLD: begin
            if (phase_done) begin
               state_d     = S_POFF;
               phase_cnt_d = '0;
               mask_d      = 3'h0;
            end
         end
         S_POFF: begin
            if (phase_done) begin
               // first entry of the chosen order
               state_d     = S_SEQ;
               phase_cnt_d = '0;
               mask_d      = ORDER_TBL[ctrl_q.power_order_sel][0];
               step_d      = 2'h1;
            end
         end
         S_SEQ: begin
            if (step_q == 2'h3 || ctrl_q.power_order_sel == ORDER_SIMUL) begin
               state_d     = S_HOLD1;
               phase_cnt_d = '0;
               mask_d      = 3'h7;
            end else if (phase_done) begin
               // next regulator after the step delay
               phase_cnt_d = '0;
               mask_d      = mask_q | ORDER_TBL[ctrl_q.power_order_sel][step_q];
               step_d      = step_q + 2'h1;
            end
         end
         default: begin
            state_d     = S_HOLD;
            phase_cnt_d = '0;
            mask_d      = 3'h7;
         end
      endcase
   end

   // origin flag, set wins over clear
   always_comb begin
      if (trip_long) begin
         flag_d = 1'b1;
      end else if (trip_other && !win_q) begin
         flag_d = 1'b0;
      end else if (clear_done) begin
         flag_d = 1'b0;
      end else begin
         flag_d = flag_q;
      end
   end

   // all timers on the one clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q     <= S_HOLD;
         phase_cnt_q <= '0;
         wd1_cnt_q   <= '0;
         wd2_cnt_q   <= '0;
         step_q      <= 2'h0;
         mask_q      <= 3'h7;
         flag_q      <= 1'b0;
      end else begin
         state_q     <= state_d;
         phase_cnt_q <= phase_cnt_d;
         wd1_cnt_q   <= wd1_cnt_d;
         wd2_cnt_q   <= wd2_cnt_d;
         step_q      <= step_d;
         mask_q      <= mask_d;
         flag_q      <= flag_d;
      end
   end

   // clear window restarts at every reset release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_q       <= 1'b0;
         clear_cnt_q <= '0;
      end else if (rst_rise) begin
         win_q       <= 1'b1;
         clear_cnt_q <= '0;
      end else if (clear_done) begin
         win_q       <= 1'b0;
      end else if (win_q) begin
         clear_cnt_q <= clear_cnt_q + cnt_t'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_prev_q <= 1'b1;
         oe_q       <= 1'b1;
         reg_en_q   <= 3'h0;
      end else begin
         rst_prev_q <= rst_active;
         oe_q       <= rst_active;
         reg_en_q   <= pins_lvl.enable & mask_q;
      end
   end

   assign reset_out_n_o          = 1'b0;
   assign reset_out_oe_o         = oe_q;
   assign reset_origin_flag_o    = 1'b0;
   assign reset_origin_flag_oe_o = flag_q;
   assign regulator_enable_o     = reg_en_q;

   // ---------------------------------------------------------------
   // wishbone slave
   // ---------------------------------------------------------------
   status_t status;
   assign status = '{clear_window: win_q, undervoltage: uv, wd1_active: wd1_active,
                     regulator_enable: reg_en_q, origin_low: flag_q,
                     reset_active: rst_active, state: state_q};

   wire        req      = cyc_i & stb_i;
   wire        hit_ctrl = (adr_i == CTRL_ADDR);
   wire        hit_stat = (adr_i == STATUS_ADDR);
   // write lands at the edge where the master sees ack
   wire        wr_ctrl  = req & we_i & ack_q & hit_ctrl & sel_i[0];
   wire [31:0] rd_data  = hit_ctrl ? {24'h000000, ctrl_q}
                        : hit_stat ? {18'h00000, status} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         dat_q  <= 32'h00000000;
         ctrl_q <= CTRL_RST;
      end else begin
         ack_q <= req & ~ack_q;
         if (req && !ack_q) begin
            dat_q <= rd_data;
         end
         if (wr_ctrl) begin
            ctrl_q <= ctrl_t'(dat_i[7:0]);
         end
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_uv_reset;
      uv |=> reset_out_oe_o;
   endproperty
   a_uv_reset: assert property (p_uv_reset) else $error("undervoltage without reset");

   property p_undervoltage_lockout_reset;
      (ctrl_q.rail_sel == RAIL_INPUT && pins_lvl.undervoltage_lockout) |=> reset_out_oe_o ##1 reset_out_oe_o;
   endproperty
   a_undervoltage_lockout_reset: assert property (p_undervoltage_lockout_reset) else $error("lockout trip without reset");

   property p_hold_release;
      $fell(reset_out_oe_o) |-> $past(phase_done, 2) && !$past(level_cause, 2)
                                && ($past(state_q, 2) == S_HOLD || $past(state_q, 2) == S_HOLD1);
   endproperty
   a_hold_release: assert property (p_hold_release) else $error("reset released early");

   property p_mr_reset;
      !mr_lvl |=> reset_out_oe_o;
   endproperty
   a_mr_reset: assert property (p_mr_reset) else $error("manual reset ignored");

   property p_wd1_trip;
      (state_q == S_RUN && wd1_exp && !wd2_exp) |=> state_q == S_HOLD ##1 reset_out_oe_o;
   endproperty
   a_wd1_trip: assert property (p_wd1_trip) else $error("first timeout without reset");

   property p_wd1_kick;
      kick1_edge |=> wd1_cnt_q == '0;
   endproperty
   a_wd1_kick: assert property (p_wd1_kick) else $error("kick did not clear counter");

   property p_wd_clear;
      rst_active |=> (wd1_cnt_q == '0 && wd2_cnt_q == '0);
   endproperty
   a_wd_clear: assert property (p_wd_clear) else $error("counter ran during reset");

   property p_wd1_float;
      (!pins_lvl.lock_mode && pins_lvl.kick1_float) |=> wd1_cnt_q == '0;
   endproperty
   a_wd1_float: assert property (p_wd1_float) else $error("floating kick not disabling");

   property p_wd1_lock;
      (pins_lvl.lock_mode && !rst_active && !kick1_edge && !wd1_exp)
         |=> wd1_cnt_q == $past(wd1_cnt_q) + cnt_t'(1);
   endproperty
   a_wd1_lock: assert property (p_wd1_lock) else $error("locked watchdog not counting");

   property p_wd2_trip;
      trip_long |=> (state_q == S_WD2_HOLD && reset_origin_flag_oe_o);
   endproperty
   a_wd2_trip: assert property (p_wd2_trip) else $error("long expiry not handled");

   property p_poff;
      (state_q == S_POFF && $past(state_q) == S_POFF) |-> regulator_enable_o == 3'h0;
   endproperty
   a_poff: assert property (p_poff) else $error("regulator on during power off");

   property p_flag_keep;
      (trip_other && win_q && !clear_done) |=> reset_origin_flag_oe_o == $past(flag_q);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag changed inside window");

   property p_wd2_off;
      (ctrl_q.wd2_sel == WD2_OFF_SEL) |=> wd2_cnt_q == '0;
   endproperty
   a_wd2_off: assert property (p_wd2_off) else $error("disabled long watchdog counted");

   c_wd1_reset:  cover property (state_q == S_RUN ##1 state_q == S_HOLD && !level_cause);
   c_wd2_cycle:  cover property (state_q == S_SEQ ##1 state_q == S_HOLD1);
   c_mr_reset:   cover property ($fell(mr_lvl));
   c_flag_clear: cover property (clear_done ##1 $fell(flag_q));

endmodule : supervisor_dual_watchdog

`default_nettype wire

// File: dv/cpu_model.sv
`default_nettype none

module cpu_model #(
   parameter int P1 = 20,
   parameter int P2 = 600
) (
   input  wire logic clk_i,
   input  wire logic run1_i,
   input  wire logic run2_i,
   output var logic  kick1_o,
   output var logic  kick2_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int c1 = 0;
   // first long toggle early: its edge must land before the long timeout
   int c2 = P2 - 8;
   initial begin
      kick1_o = 1'b0;
      kick2_o = 1'b0;
   end
   always @(posedge clk_i) begin
      c1 <= (c1 == P1 - 1) ? 0 : c1 + 1;
      if (run1_i && c1 == P1 - 1) kick1_o <= ~kick1_o;
   end
   // long kick, each level held past the filter
   always @(posedge clk_i) begin
      c2 <= (c2 == P2 - 1) ? 0 : c2 + 1;
      if (run2_i && c2 == P2 - 1) kick2_o <= ~kick2_o;
   end
endmodule : cpu_model

`default_nettype wire

// File: dv/supervisor_dual_watchdog_tb_top.sv
`default_nettype none

module supervisor_dual_watchdog_tb_top;
   import supervisor_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic        mr_n = 1'b1, flt = 1'b0, lock = 1'b0, uv = 1'b0, run1 = 1'b0, run2 = 1'b0;
   logic        k1, k2, rst_oe, flag_oe, rst_n, flag_n;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, r = 32'h127a16c7;
   logic [3:0]  below = 4'h0;
   logic [2:0]  ren = 3'h7, rout;
   logic [1:0]  ord;
   logic [2:0]  first_en [4] = '{3'h2, 3'h1, 3'h2, 3'h7};
   logic [31:0] q[$];
   int          err_count = 0, cmp_count = 0;
   always #4 clk_i = ~clk_i;

   supervisor_dual_watchdog #(
      .HOLD_CYC(cnt_t'(20)), .HOLD1_CYC(cnt_t'(20)), .HOLD2_CYC(cnt_t'(20)), .POFF_CYC(cnt_t'(30)),
      .STEP_CYC(cnt_t'(10)), .CLEAR_CYC(cnt_t'(200)), .WD1_CYC({cnt_t'(100), cnt_t'(50)}),
      .WD2_CYC({7{cnt_t'(700)}})
   ) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .manual_reset_n_i(mr_n), .short_wd_kick_i(k1),
      .short_wd_kick_float_i(flt), .long_wd_kick_i(k2), .short_wd_lock_mode_i(lock),
      .rail_below_i(below), .undervoltage_lockout_i(uv), .regulator_enable_i(ren),
      .reset_out_n_o(rst_n), .reset_out_oe_o(rst_oe), .reset_origin_flag_o(flag_n),
      .reset_origin_flag_oe_o(flag_oe), .regulator_enable_o(rout));
   cpu_model cpu (.clk_i(clk_i), .run1_i(run1), .run2_i(run2), .kick1_o(k1), .kick2_o(k2));

   // ----------------------------
   // helpers
   // ----------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("mismatches %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   function automatic logic [2:0] pick(input int k);
      return k == 0 ? {2'h0, rst_oe} : k == 1 ? {2'h0, flag_oe} : rout;
   endfunction : pick
   // bounded wait; a spent bound ends the run
   task automatic waitv(input int k, input logic [2:0] v, input int n);
      int i;
      for (i = 0; i < n && pick(k) !== v; i++) @(posedge clk_i);
      check({29'h0, pick(k)}, {29'h0, v});
      if (i == n) give_verdict();
   endtask : waitv
   // reads leave their expected data in the queue
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      if (!w) q.push_back(d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i == 20) begin
         err_count++;
         give_verdict();
      end
   endtask : wb
   always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0) check(rdat, q.pop_front());

   // ----------------------------
   // main sequence
   // ----------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      run1 <= 1'b1;
      run2 <= 1'b1;
      repeat (15) @(posedge clk_i);
      check({31'h0, rst_oe}, 32'h1);
      waitv(0, 3'h0, 40);
      r = lfsr(r);
      ord = r[1:0];
      wb(1'b0, CTRL_ADDR, 32'h1);
      wb(1'b0, 8'h08, 32'h0);
      wb(1'b1, CTRL_ADDR, {30'h0, ord});
      wb(1'b0, CTRL_ADDR, {30'h0, ord});
      ren <= r[10:8];
      repeat (8) @(posedge clk_i);
      check({29'h0, rout}, {29'h0, ren});
      below <= 4'h1;
      waitv(0, 3'h1, 10);
      below <= 4'h0;
      repeat (15) @(posedge clk_i);
      check({31'h0, rst_oe}, 32'h1);
      waitv(0, 3'h0, 40);
      mr_n <= 1'b0;
      repeat (5) @(posedge clk_i);
      mr_n <= 1'b1;
      repeat (25) @(posedge clk_i);
      check({31'h0, rst_oe}, 32'h0);
      mr_n <= 1'b0;
      waitv(0, 3'h1, 30);
      mr_n <= 1'b1;
      repeat (25) @(posedge clk_i);
      check({31'h0, rst_oe}, 32'h1);
      waitv(0, 3'h0, 40);
      run1 <= 1'b0;
      waitv(0, 3'h1, 80);
      flt <= 1'b1;
      waitv(0, 3'h0, 60);
      repeat (150) @(posedge clk_i);
      check({31'h0, rst_oe}, 32'h0);
      lock <= 1'b1;
      waitv(0, 3'h1, 80);
      lock <= 1'b0;
      flt <= 1'b0;
      run1 <= 1'b1;
      ren <= 3'h7;
      waitv(0, 3'h0, 60);
      run2 <= 1'b0;
      waitv(1, 3'h1, 1400);
      waitv(2, 3'h0, 40);
      waitv(2, first_en[ord], 60);
      repeat (5) @(posedge clk_i);
      check({29'h0, rout}, {29'h0, first_en[ord]});
      waitv(2, 3'h7, 40);
      run2 <= 1'b1;
      waitv(0, 3'h0, 60);
      run1 <= 1'b0;
      waitv(0, 3'h1, 80);
      run1 <= 1'b1;
      waitv(0, 3'h0, 60);
      check({31'h0, flag_oe}, 32'h1);
      waitv(1, 3'h0, 220);
      give_verdict();
   end
endmodule : supervisor_dual_watchdog_tb_top

`default_nettype wire
